// File: hw/scc_defines.vh
// offsets, field positions, reset values and counts of the capture/compare unit
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
`define SCC_NCH        16
`define SCC_NSYNC      18
// register byte offsets (low byte of haddr, upper bits must be zero)
`define SCC_OFF_CTRL   8'h00
`define SCC_OFF_T0CFG  8'h04
`define SCC_OFF_T1CFG  8'h08
`define SCC_OFF_T0CNT  8'h0C
`define SCC_OFF_T1CNT  8'h10
`define SCC_OFF_T0REL  8'h14
`define SCC_OFF_T1REL  8'h18
`define SCC_OFF_STAT   8'h1C
`define SCC_OFF_MASK   8'h20
`define SCC_OFF_PINS   8'h24
// channel pages: 0x40 + 4*n config, 0x80 + 4*n value
`define SCC_PAGE_CFG   2'h1
`define SCC_PAGE_VAL   2'h2
// control register fields
`define SCC_CTRL_RUN0  0
`define SCC_CTRL_RUN1  1
`define SCC_CTRL_STAG  2
// timer config fields and count sources
`define SCC_TCFG_SRC   1:0
`define SCC_TCFG_PRE   4:2
`define SCC_SRC_PRE    2'h0
`define SCC_SRC_AUX    2'h1
`define SCC_SRC_EXTR   2'h2
`define SCC_SRC_EXTF   2'h3
// channel config fields
`define SCC_CH_MODE    2:0
`define SCC_CH_EDGE    4:3
`define SCC_CH_TSEL    5
`define SCC_CH_ONCE    6
`define SCC_CH_DBL     7
// channel modes
`define SCC_MODE_OFF   3'h0
`define SCC_MODE_CAP   3'h1
`define SCC_MODE_CMP0  3'h4
`define SCC_MODE_CMP1  3'h5
`define SCC_MODE_CMP2  3'h6
`define SCC_MODE_CMP3  3'h7
// reset values
`define SCC_RST_CTRL   3'h0
`define SCC_RST_TCFG   5'h00
`define SCC_RST_CNT    16'h0000
`define SCC_RST_CHCFG  8'h00
`define SCC_RST_MASK   16'h0000
// timing counts
`define SCC_STAG_SLOT  3'h7
`define SCC_CNT_TOP    16'hFFFF
`endif

// File: hw/scc_timer.v
// one reloadable 16-bit time base with selectable count source
`include "scc_defines.vh"
module scc_timer (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// configuration
	input  wire        run,
	input  wire        stag,
	input  wire [1:0]  src,
	input  wire [2:0]  pre,
	// count events
	input  wire        auxOvf,
	input  wire        extRise,
	input  wire        extFall,
	// software access
	input  wire        wrCnt,
	input  wire        wrRel,
	input  wire [15:0] wdata,
	// state
	output wire [15:0] cnt,
	output wire [15:0] rel,
	output wire        chg,
	output wire        ovf
);
	reg  [6:0]  preCnt_ff;
	reg  [2:0]  phase_ff;
	reg         pend_ff;
	reg  [15:0] cnt_ff;
	reg  [15:0] rel_ff;
	reg         chg_ff;
	reg         ovf_ff;
	reg         raw;
	wire [6:0]  preMask = 7'h7F >> (3'h7 - pre);
	wire        preTick = &(preCnt_ff | ~preMask);
	// staggered: one count slot in eight; events between slots merge into one held count
	wire        slot    = ~stag | (phase_ff == `SCC_STAG_SLOT);
	wire        step    = run & (raw | pend_ff) & slot;

	always @*
	begin
		case (src)
		`SCC_SRC_PRE:  raw = preTick;
		`SCC_SRC_AUX:  raw = auxOvf;
		`SCC_SRC_EXTR: raw = extRise;
		`SCC_SRC_EXTF: raw = extFall;
		default:       raw = 1'b0;
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			preCnt_ff <= 7'h00;
			phase_ff  <= 3'h0;
			pend_ff   <= 1'b0;
			cnt_ff    <= `SCC_RST_CNT;
			rel_ff    <= `SCC_RST_CNT;
			chg_ff    <= 1'b0;
			ovf_ff    <= 1'b0;
		end
		else
		begin
			preCnt_ff <= preCnt_ff + 7'h01;
			phase_ff  <= phase_ff + 3'h1;
			pend_ff   <= run & (raw | pend_ff) & ~slot;
			chg_ff    <= step & ~wrCnt;
			ovf_ff    <= step & ~wrCnt & (cnt_ff == `SCC_CNT_TOP);
			if (wrRel)
				rel_ff <= wdata;
			if (wrCnt)
				cnt_ff <= wdata;
			else if (step && cnt_ff == `SCC_CNT_TOP)
				cnt_ff <= rel_ff;
			else if (step)
				cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	assign cnt = cnt_ff;
	assign rel = rel_ff;
	assign chg = chg_ff;
	assign ovf = ovf_ff;
endmodule // scc_timer

// File: hw/scc_top.v
// capture/compare unit: ahb-lite slave, pin conditioning, 16 channels
`include "scc_defines.vh"
module scc_top (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	// channel pins
	input  wire [15:0] ccPinIn,
	output wire [15:0] ccPinOut,
	output wire [15:0] ccPinOe,
	// count inputs
	input  wire [1:0]  extCountIn,
	input  wire        auxTimerSixOvf,
	// interrupt
	output wire        irq
);
	reg  [31:0] hrdata_ff;
	reg         wrPend_ff;
	reg  [7:0]  wrAddr_ff;
	reg  [2:0]  ctrl_ff;
	reg  [4:0]  tcfg0_ff;
	reg  [4:0]  tcfg1_ff;
	reg  [15:0] mask_ff;
	reg  [15:0] status_ff;
	reg  [31:0] rdMux;
	wire [15:0] cnt0;
	wire [15:0] cnt1;
	wire [15:0] rel0;
	wire [15:0] rel1;
	wire        chg0;
	wire        chg1;
	wire        ovf0;
	wire        ovf1;
	wire [17:0] rawIn = {extCountIn, ccPinIn};
	wire [17:0] lvlW;
	wire [17:0] riseW;
	wire [17:0] fallW;
	wire [15:0] matchW;
	wire [15:0] evtW;
	wire [15:0] partnerMatch = {8'h00, matchW[15:8]};
	wire [7:0]  chCfgW [0:15];
	wire [15:0] chValW [0:15];

	// bus: word transfers only, other sizes are ignored
	// only the low 256 bytes decode; higher addresses are ignored and the read data holds
	wire        hit    = (haddr[31:8] == 24'h000000);
	wire        acc    = hsel & htrans[1] & hready & (hsize == 3'h2) & hit;
	wire        rdAcc  = acc & ~hwrite;
	wire        statRd = rdAcc & (haddr[7:0] == `SCC_OFF_STAT);
	wire [15:0] wd     = hwdata[15:0];

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
		end
		else
		begin
			wrPend_ff <= acc & hwrite;
			wrAddr_ff <= haddr[7:0];
			// read data taken in the address phase: no wait states
			if (rdAcc)
				hrdata_ff <= rdMux;
		end
	end

	// writes land one edge after the address phase, when hwdata stands
	wire wrCtrl  = wrPend_ff & (wrAddr_ff == `SCC_OFF_CTRL);
	wire wrT0Cfg = wrPend_ff & (wrAddr_ff == `SCC_OFF_T0CFG);
	wire wrT1Cfg = wrPend_ff & (wrAddr_ff == `SCC_OFF_T1CFG);
	wire wrT0Cnt = wrPend_ff & (wrAddr_ff == `SCC_OFF_T0CNT);
	wire wrT1Cnt = wrPend_ff & (wrAddr_ff == `SCC_OFF_T1CNT);
	wire wrT0Rel = wrPend_ff & (wrAddr_ff == `SCC_OFF_T0REL);
	wire wrT1Rel = wrPend_ff & (wrAddr_ff == `SCC_OFF_T1REL);
	wire wrMask  = wrPend_ff & (wrAddr_ff == `SCC_OFF_MASK);

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ctrl_ff  <= `SCC_RST_CTRL;
			tcfg0_ff <= `SCC_RST_TCFG;
			tcfg1_ff <= `SCC_RST_TCFG;
			mask_ff  <= `SCC_RST_MASK;
		end
		else
		begin
			if (wrCtrl)
				ctrl_ff <= hwdata[2:0];
			if (wrT0Cfg)
				tcfg0_ff <= hwdata[4:0];
			if (wrT1Cfg)
				tcfg1_ff <= hwdata[4:0];
			if (wrMask)
				mask_ff <= wd;
		end
	end

	// a new event in the reading cycle survives the clear
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			status_ff <= 16'h0000;
		else if (statRd)
			status_ff <= evtW;
		else
			status_ff <= status_ff | evtW;
	end

	// level output: drops only by a status read or a mask write
	assign irq = |(status_ff & mask_ff);

	always @*
	begin
		rdMux = 32'h00000000;
		case (haddr[7:0])
		`SCC_OFF_CTRL:  rdMux = {29'h0, ctrl_ff};
		`SCC_OFF_T0CFG: rdMux = {27'h0, tcfg0_ff};
		`SCC_OFF_T1CFG: rdMux = {27'h0, tcfg1_ff};
		`SCC_OFF_T0CNT: rdMux = {16'h0, cnt0};
		`SCC_OFF_T1CNT: rdMux = {16'h0, cnt1};
		`SCC_OFF_T0REL: rdMux = {16'h0, rel0};
		`SCC_OFF_T1REL: rdMux = {16'h0, rel1};
		`SCC_OFF_STAT:  rdMux = {16'h0, status_ff};
		`SCC_OFF_MASK:  rdMux = {16'h0, mask_ff};
		`SCC_OFF_PINS:  rdMux = {ccPinOut, lvlW[15:0]};
		default:
		begin
			if (haddr[7:6] == `SCC_PAGE_CFG)
				rdMux = {24'h0, chCfgW[haddr[5:2]]};
			else if (haddr[7:6] == `SCC_PAGE_VAL)
				rdMux = {16'h0, chValW[haddr[5:2]]};
		end
		endcase
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// pin conditioning: a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `SCC_NSYNC; gi = gi + 1)
		begin : gSync
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			reg prim_ff;
			reg lvl_ff;
			reg rise_ff;
			reg fall_ff;
			wire agree = (s2_ff == s3_ff);
			always @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					s1_ff   <= 1'b0;
					s2_ff   <= 1'b0;
					s3_ff   <= 1'b0;
					prim_ff <= 1'b0;
					lvl_ff  <= 1'b0;
					rise_ff <= 1'b0;
					fall_ff <= 1'b0;
				end
				else
				begin
					s1_ff <= rawIn[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// first agreed level after reset loads without an edge
					if (agree)
					begin
						prim_ff <= 1'b1;
						lvl_ff  <= s3_ff;
					end
					rise_ff <= agree & prim_ff & s3_ff & ~lvl_ff;
					fall_ff <= agree & prim_ff & ~s3_ff & lvl_ff;
				end
			end
			assign lvlW[gi]  = lvl_ff;
			assign riseW[gi] = rise_ff;
			assign fallW[gi] = fall_ff;
		end
	endgenerate

	// both timers leave reset with the same stagger phase, slots line up
	scc_timer uTimer0 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.run     (ctrl_ff[`SCC_CTRL_RUN0]),
		.stag    (ctrl_ff[`SCC_CTRL_STAG]),
		.src     (tcfg0_ff[`SCC_TCFG_SRC]),
		.pre     (tcfg0_ff[`SCC_TCFG_PRE]),
		.auxOvf  (auxTimerSixOvf),
		.extRise (riseW[16]),
		.extFall (fallW[16]),
		.wrCnt   (wrT0Cnt),
		.wrRel   (wrT0Rel),
		.wdata   (wd),
		.cnt     (cnt0),
		.rel     (rel0),
		.chg     (chg0),
		.ovf     (ovf0)
	);

	scc_timer uTimer1 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.run     (ctrl_ff[`SCC_CTRL_RUN1]),
		.stag    (ctrl_ff[`SCC_CTRL_STAG]),
		.src     (tcfg1_ff[`SCC_TCFG_SRC]),
		.pre     (tcfg1_ff[`SCC_TCFG_PRE]),
		.auxOvf  (auxTimerSixOvf),
		.extRise (riseW[17]),
		.extFall (fallW[17]),
		.wrCnt   (wrT1Cnt),
		.wrRel   (wrT1Rel),
		.wdata   (wd),
		.cnt     (cnt1),
		.rel     (rel1),
		.chg     (chg1),
		.ovf     (ovf1)
	);

	// channels; compare only on a fresh timer value, so a stopped
	// timer never repeats a match
	generate
		for (gi = 0; gi < `SCC_NCH; gi = gi + 1)
		begin : gCh
			localparam [3:0] IDX = gi;
			reg  [15:0] val_ff;
			reg  [7:0]  cfg_ff;
			reg         armed_ff;
			reg         done_ff;
			reg         pin_ff;
			wire [2:0]  mode  = cfg_ff[`SCC_CH_MODE];
			wire [1:0]  edg   = cfg_ff[`SCC_CH_EDGE];
			wire        tsel  = cfg_ff[`SCC_CH_TSEL];
			wire [15:0] tv    = tsel ? cnt1 : cnt0;
			wire        tchg  = tsel ? chg1 : chg0;
			wire        tovf  = tsel ? ovf1 : ovf0;
			wire        isCap = (mode == `SCC_MODE_CAP);
			wire        isCmp = mode[2];
			wire        once  = (mode == `SCC_MODE_CMP2) |
			                    (mode == `SCC_MODE_CMP3);
			wire        dblOn = isCmp & cfg_ff[`SCC_CH_DBL];
			wire        wrCfg = wrPend_ff & (wrAddr_ff[5:2] == IDX) &
			                    (wrAddr_ff[7:6] == `SCC_PAGE_CFG);
			wire        wrVal = wrPend_ff & (wrAddr_ff[5:2] == IDX) &
			                    (wrAddr_ff[7:6] == `SCC_PAGE_VAL);
			wire        capEvt = isCap &
			                     ((edg[0] & riseW[gi]) |
			                      (edg[1] & fallW[gi]));
			wire        match = isCmp & tchg & (tv == val_ff) &
			                    armed_ff & ~(once & done_ff);
			// a double-mode channel 0 to 7 also toggles on the match of its partner, channel n+8
			wire        tog   = dblOn ? (match | partnerMatch[gi])
			                    : (match & (mode == `SCC_MODE_CMP1));
			always @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					val_ff   <= `SCC_RST_CNT;
					cfg_ff   <= `SCC_RST_CHCFG;
					armed_ff <= 1'b0;
					done_ff  <= 1'b0;
					pin_ff   <= 1'b0;
				end
				else
				begin
					if (wrCfg)
						cfg_ff <= hwdata[7:0];
					// capture beats a software write in the same cycle
					if (capEvt)
						val_ff <= tv;
					else if (wrVal)
						val_ff <= wd;
					if (wrCfg)
						armed_ff <= 1'b1;
					else if (match && cfg_ff[`SCC_CH_ONCE])
						armed_ff <= 1'b0;
					// once-per-period flag; a match beats a same-cycle overflow
					if (wrCfg)
						done_ff <= 1'b0;
					else if (match)
						done_ff <= 1'b1;
					else if (tovf)
						done_ff <= 1'b0;
					if (tog)
						pin_ff <= ~pin_ff;
					else if (mode == `SCC_MODE_CMP3 && match)
						pin_ff <= 1'b1;
					else if (mode == `SCC_MODE_CMP3 && tovf)
						pin_ff <= 1'b0;
				end
			end
			assign matchW[gi]   = match;
			// without the double bit, compare modes zero and two touch no pin
			assign evtW[gi]     = capEvt | match;
			assign ccPinOut[gi] = pin_ff;
			assign ccPinOe[gi]  = dblOn |
			                      (mode == `SCC_MODE_CMP1) |
			                      (mode == `SCC_MODE_CMP3);
			assign chCfgW[gi]   = cfg_ff;
			assign chValW[gi]   = val_ff;
		end
	endgenerate
endmodule // scc_top

// File: tb/scc_top_asserts.sv
// port checker of the capture/compare unit
module scc_top_asserts (
	// clock and reset
	input logic        sys_clk,
	input logic        rst_n,
	// bus
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic        hready,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata,
	// pins and interrupt
	input logic [15:0] ccPinOut,
	input logic [15:0] ccPinOe,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	wire acc = hsel && htrans[1] && hready && hsize == 3'h2
		&& haddr[31:8] == 24'h0;
	wire rdAcc = acc && !hwrite;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_reset_quiet: assert property ($rose(rst_n) |-> !irq
		&& ccPinOut == 16'h0 && hrdata == 32'h0)
		else $error("outputs not quiet after reset");
	a_oe_reset: assert property ($rose(rst_n) |-> (ccPinOe == 16'h0) [*2])
		else $error("pin driven right after reset");
	a_rdata_hold: assert property (!rdAcc |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_oe_cause: assert property ($changed(ccPinOe) |-> $past(acc && hwrite, 2))
		else $error("pin enable changed without a write");
	a_irq_fall: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
		else $error("interrupt fell without bus access");
	a_pins_read: assert property (rdAcc && haddr[7:0] == 8'h24
		|=> hrdata[31:16] == $past(ccPinOut))
		else $error("pin levels read back wrong");
	a_upper_zero: assert property (rdAcc && haddr[7:0] != 8'h24
		|=> hrdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	c_pins_read: cover property (rdAcc && haddr[7:0] == 8'h24);
	c_irq_rise: cover property ($rose(irq));
	c_oe_rise: cover property ($rose(ccPinOe[3]));
endmodule // scc_top_asserts
bind scc_top scc_top_asserts chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .ccPinOut(ccPinOut), .ccPinOe(ccPinOe), .irq(irq));

// File: tb/scc_pins.sv
// far-side pin model: capture inputs, count inputs, output watcher
module scc_pins (
	// clock
	input  logic        sys_clk,
	// channel pins
	input  logic [15:0] ccPinOut,
	input  logic [15:0] ccPinOe,
	output logic [15:0] ccPinIn,
	// count inputs
	output logic [1:0]  extCountIn,
	output logic        auxTimerSixOvf
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pinLvl = 16'h0000;
	logic [15:0] lastOut = 16'h0000;
	int          togs [16];
	// a driven pin reads back its own level
	assign ccPinIn = (ccPinOe & ccPinOut) | (~ccPinOe & pinLvl);
	initial
	begin
		extCountIn = 2'h0;
		auxTimerSixOvf = 1'b0;
		foreach (togs[i])
			togs[i] = 0;
	end
	// count output transitions per pin
	always @(posedge sys_clk)
	begin
		foreach (togs[i])
			// unknown levels before reset count as no change
			if ((ccPinOut[i] ^ lastOut[i]) === 1'b1)
				togs[i]++;
		lastOut <= ccPinOut;
	end
	task setPin(int idx, logic lvl);
		@(posedge sys_clk);
		pinLvl[idx] <= lvl;
	endtask
	// held four cycles each way so the input filter accepts it
	task countPulses(int n, int b);
		repeat (n)
		begin
			@(posedge sys_clk);
			extCountIn[b] <= 1'b1;
			repeat (4) @(posedge sys_clk);
			extCountIn[b] <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask
	// one-cycle overflow pulses
	task auxPulses(int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			auxTimerSixOvf <= 1'b1;
			@(posedge sys_clk);
			auxTimerSixOvf <= 1'b0;
		end
	endtask
endmodule // scc_pins

// File: tb/scc_top_test.sv
// self-checking bench of the capture/compare unit
module scc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, rst_n, hsel, hwrite;
	logic [31:0] haddr, hwdata, d;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hreadyout, hresp, irq, auxTimerSixOvf;
	wire  [31:0] hrdata;
	wire  [15:0] ccPinIn, ccPinOut, ccPinOe;
	wire  [1:0]  extCountIn;
	int          nFail, samplesChecked, cycles, e;
	int          chTab [7] = '{0, 1, 2, 3, 4, 5, 13};
	logic [7:0]  cfgTab [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h45, 8'h85,
		8'h04};
	logic [15:0] valTab [7] = '{16'hFFFD, 16'hFFFD, 16'hFFFD, 16'hFFFE,
		16'hFFFD, 16'hFFFC, 16'hFFFE};
	scc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ccPinIn(ccPinIn),
		.ccPinOut(ccPinOut), .ccPinOe(ccPinOe), .extCountIn(extCountIn),
		.auxTimerSixOvf(auxTimerSixOvf), .irq(irq));
	scc_pins far (.sys_clk(sys_clk), .ccPinOut(ccPinOut),
		.ccPinOe(ccPinOe), .ccPinIn(ccPinIn), .extCountIn(extCountIn),
		.auxTimerSixOvf(auxTimerSixOvf));
	always #20 sys_clk = ~sys_clk;
	// a hang ends the run as a mismatch
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nFail++;
			finishTest();
		end
	end
	task finishTest;
		$display("checks %0d mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(string nm, logic [31:0] x, logic [31:0] got);
		samplesChecked++;
		if (got !== x)
		begin
			$display("wrong value %s expected %h seen %h", nm, x, got);
			nFail++;
		end
	endtask
	task xfer(logic [7:0] a, logic w, logic [31:0] v);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		d = hrdata;
	endtask
	task wr(logic [7:0] a, logic [31:0] v);
		xfer(a, 1'b1, v);
	endtask
	task rc(logic [7:0] a, logic [31:0] m, logic [31:0] x, string nm);
		xfer(a, 1'b0, 32'h0);
		chk(nm, x, d & m);
	endtask
	initial
	begin
		sys_clk = 0;
		rst_n = 0;
		hsel = 0;
		haddr = 0;
		htrans = 0;
		hwrite = 0;
		hsize = 3'h2;
		hwdata = 0;
		nFail = 0;
		samplesChecked = 0;
		cycles = 0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rc(8'h00, '1, 32'h0, "ctrl");
		rc(8'h0C, '1, 32'h0, "t0cnt");
		rc(8'h40, '1, 32'h0, "chcfg0");
		wr(8'h28, '1);
		rc(8'h28, '1, 32'h0, "unmapped");
		$display("test reset done");
		wr(8'h20, 32'h40);
		for (e = 1; e < 4; e++)
		begin
			wr(8'h58, 32'h21 | (e << 3));
			wr(8'h10, 32'h1000 + e);
			far.setPin(6, 1'b1);
			repeat (10) @(posedge sys_clk);
			chk("irq rise", e & 1, irq);
			rc(8'h1C, 32'h40, (e & 1) << 6, "stat rise");
			far.setPin(6, 1'b0);
			repeat (10) @(posedge sys_clk);
			chk("irq fall", e >> 1, irq);
			rc(8'h1C, 32'h40, (e >> 1) << 6, "stat fall");
			rc(8'h98, 32'hFFFF, 32'h1000 + e, "capture");
		end
		$display("test capture done");
		wr(8'h04, 32'h2);
		wr(8'h14, 32'hFFFC);
		wr(8'h0C, 32'hFFFC);
		for (e = 0; e < 7; e++)
		begin
			wr(8'(8'h80 + 4 * chTab[e]), {16'h0, valTab[e]});
			wr(8'(8'h40 + 4 * chTab[e]), {24'h0, cfgTab[e]});
		end
		wr(8'h00, 32'h1);
		far.countPulses(1, 0);
		repeat (8) @(posedge sys_clk);
		rc(8'h1C, 32'h17, 32'h17, "stat first");
		wr(8'h0C, 32'hFFFC);
		far.countPulses(1, 0);
		repeat (8) @(posedge sys_clk);
		rc(8'h1C, 32'h17, 32'h03, "stat again");
		far.countPulses(4, 0);
		repeat (8) @(posedge sys_clk);
		rc(8'h1C, 32'h05, 32'h05, "stat rearm");
		rc(8'h24, 32'hFFFF0000, 32'h00120000, "pins");
		chk("toggles ch1", 3, far.togs[1]);
		chk("edges ch3", 2, far.togs[3]);
		chk("toggles ch4", 1, far.togs[4]);
		chk("toggles ch5", 2, far.togs[5]);
		chk("pin enable", 32'h0000003A, ccPinOe);
		rc(8'h0C, 32'hFFFF, 32'hFFFD, "ext count");
		$display("test compare done");
		wr(8'h08, 32'h1);
		wr(8'h10, 32'h0);
		wr(8'h00, 32'h3);
		far.auxPulses(3);
		repeat (4) @(posedge sys_clk);
		rc(8'h10, 32'hFFFF, 32'h3, "aux count");
		$display("test aux done");
		// 66 run edges: divide by four gives 16 or 17, stagger 8 or 9
		for (e = 0; e < 2; e++)
		begin
			wr(8'h00, 32'h0);
			wr(8'h04, e ? 32'h0 : 32'h8);
			wr(8'h0C, 32'h0);
			wr(8'h00, e ? 32'h5 : 32'h1);
			repeat (64) @(posedge sys_clk);
			wr(8'h00, 32'h0);
			xfer(8'h0C, 1'b0, 32'h0);
			chk("slow count", 1, (d == (16 >> e)) || (d == (16 >> e) + 1));
		end
		$display("test prescale done");
		finishTest();
	end
endmodule // scc_top_test
